// *** rtl/frpc_pkg.sv ***
// Shared constants, types and helpers for the flash region program control block
package frpc_pkg;

    // -----------------------------------------------------------------
    // Array geometry and factory configuration
    // -----------------------------------------------------------------
    localparam int unsigned  FLASH_BYTES    = 4096;
    localparam logic [15:0]  BOOT_START_RST = 16'h0C00;
    localparam logic [7:0]   LOW_BOUND_RST  = 8'h08;
    localparam logic         LOCK_RST       = 1'b1;
    localparam logic [7:0]   BOUND_SCALE    = 8'h08;
    localparam logic [7:0]   CMD_KEY_FIRST  = 8'h46;
    localparam logic [7:0]   CMD_KEY_SECOND = 8'hB9;
    localparam logic [2:0]   OP_CYCLES      = 3'h4;

    // -----------------------------------------------------------------
    // Register offsets and field positions
    // -----------------------------------------------------------------
    localparam logic [7:0]   OFS_CTRL  = 8'h00;
    localparam logic [7:0]   OFS_MODE  = 8'h04;
    localparam logic [7:0]   OFS_ADDR  = 8'h08;
    localparam logic [7:0]   OFS_DATA  = 8'h0C;
    localparam logic [7:0]   OFS_CMD   = 8'h10;
    localparam logic [7:0]   OFS_BOUND = 8'h14;
    localparam logic [7:0]   OFS_STAT  = 8'h18;
    localparam logic [7:0]   OFS_ISTS  = 8'h1C;
    localparam logic [7:0]   OFS_IMSK  = 8'h20;
    localparam int           CTRL_EN_BIT   = 7;
    localparam int           CTRL_FAIL_BIT = 4;
    localparam int           CTRL_LOCK_BIT = 0;
    localparam int           IRQ_DONE_BIT  = 0;
    localparam int           IRQ_FAIL_BIT  = 1;
    localparam logic [1:0]   RESP_OKAY     = 2'h0;
    localparam logic [1:0]   RESP_SLVERR   = 2'h2;

    // -----------------------------------------------------------------
    // Enumerations
    // -----------------------------------------------------------------
    localparam logic [2:0]   OP_STANDBY = 3'h0;
    localparam logic [2:0]   OP_READ    = 3'h1;
    localparam logic [2:0]   OP_PROG    = 3'h2;
    localparam logic [2:0]   OP_PAGEP   = 3'h4;

    typedef enum logic [1:0] {
        REG_APP  = 2'h0,
        REG_DATA = 2'h1,
        REG_BOOT = 2'h2
    } frpc_region_e;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_CHECK = 2'b01,
        ST_RUN   = 2'b11,
        ST_DONE  = 2'b10
    } frpc_fsm_e;

    // -----------------------------------------------------------------
    // State carriers
    // -----------------------------------------------------------------
    typedef struct packed {
        frpc_fsm_e   fsm;
        logic        op_en;
        logic        fail;
        logic        lock;
        logic [2:0]  mode;
        logic [11:0] addr;
        logic [7:0]  data;
        logic [7:0]  bound;
        logic [1:0]  irq_sts;
        logic [1:0]  irq_msk;
        logic [2:0]  cnt;
        logic        arr_we;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        irq;
        logic        halt;
    } frpc_state_s;

    typedef struct packed {
        logic armed;
        logic fire;
    } frpc_seq_s;

    // -----------------------------------------------------------------
    // Region classification
    // -----------------------------------------------------------------
    function automatic frpc_region_e frpc_region(input logic [11:0] addr,
                                                 input logic [7:0]  bound);
        logic [15:0] a;
        a = {4'h0, addr};
        if (a >= BOOT_START_RST) begin
            frpc_region = REG_BOOT;
        end else if (a >= {bound, 8'h00}) begin
            frpc_region = REG_DATA;
        end else begin
            frpc_region = REG_APP;
        end
    endfunction : frpc_region

endpackage : frpc_pkg

// *** rtl/frpc_cmd_seq.sv ***
// Two-key command port sequence detector
module frpc_cmd_seq (
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rstn,
    // Command port write
    input  wire logic       i_wr,
    input  wire logic [7:0] i_byte,
    input  wire logic       i_enable,
    // Launch pulse
    output logic            o_fire
);
    frpc_pkg::frpc_seq_s st_ff;
    frpc_pkg::frpc_seq_s nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.fire = 1'b0;
        if (i_wr) begin
            if (i_byte == frpc_pkg::CMD_KEY_FIRST) begin
                nxt_st.armed = 1'b1;
            end else begin
                nxt_st.fire  = st_ff.armed && i_byte == frpc_pkg::CMD_KEY_SECOND
                               && i_enable;
                nxt_st.armed = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_fire = st_ff.fire;
endmodule : frpc_cmd_seq

// *** rtl/frpc_array.sv ***
// Byte-wide flash storage array
module frpc_array #(
    parameter int unsigned DEPTH = frpc_pkg::FLASH_BYTES
) (
    // Clock
    input  wire logic        i_clock,
    // Access port
    input  wire logic        i_we,
    input  wire logic [11:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    output logic [7:0]       o_rdata
);
    logic [7:0] mem [DEPTH];
    logic [7:0] rdata_ff;

    always_ff @(posedge i_clock) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        rdata_ff <= mem[i_addr];
    end

    assign o_rdata = rdata_ff;
endmodule : frpc_array

// *** rtl/frpc_top.sv ***
// Flash region program control: register slave, permission check, core freeze
//
// Summary of operation
// (RULE1) One 4K array, three regions
// (RULE2) Boot code may program application or data
// (RULE3) Application code may program data only
// (RULE4) Halt core during flash operation
// (RULE5) Release core when operation completes
// (RULE6) Defer interrupts until operation finishes
// (RULE7) Reset: 1K boot, 1K data, lock
// (RULE8) Enable, then keys 46 B9 launch
// (RULE9) Select: standby, read, program, bound write
// (RULE10) Fail flag bit 4, cleared on success
// (RULE11) Data region from bound times 256
// (RULE12) Check fetch and target before array access; only program is checked, reads go to the array unchecked
module frpc_top (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    // AXI4-Lite write address and data
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    // AXI4-Lite write response
    output logic             o_bvalid,
    input  wire logic        i_bready,
    output logic [1:0]       o_bresp,
    // AXI4-Lite read
    input  wire logic        i_arvalid,
    output logic             o_arready,
    input  wire logic [7:0]  i_araddr,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    // Core side
    input  wire logic [11:0] i_fetch_addr,
    output logic             o_core_halt,
    output logic             o_irq_defer,
    // Interrupt
    output logic             o_irq
);
    // -----------------------------------------------------------------
    // State and sub-blocks
    // -----------------------------------------------------------------
    frpc_pkg::frpc_state_s st_ff;
    frpc_pkg::frpc_state_s nxt_st;
    logic                  seq_wr;
    logic                  seq_fire;
    logic [7:0]            arr_rdata;
    logic                  wr_go;
    logic                  rd_go;
    logic                  permit;
    frpc_pkg::frpc_region_e fetch_reg;
    frpc_pkg::frpc_region_e target_reg;

    assign wr_go      = st_ff.awready && st_ff.wready;
    assign rd_go      = st_ff.arready;
    assign seq_wr     = wr_go && i_awaddr == frpc_pkg::OFS_CMD && i_wstrb[0]
                        && st_ff.fsm == frpc_pkg::ST_IDLE;
    assign fetch_reg  = frpc_pkg::frpc_region(i_fetch_addr, st_ff.bound);  // [RULE11]
    assign target_reg = frpc_pkg::frpc_region(st_ff.addr, st_ff.bound);    // [RULE11]

    // Permission from fetch region and target region
    always_comb begin
        permit = 1'b0;                                                     // [RULE12]
        if (fetch_reg == frpc_pkg::REG_BOOT) begin
            permit = target_reg != frpc_pkg::REG_BOOT;                     // [RULE2]
        end else begin
            permit = target_reg == frpc_pkg::REG_DATA;                     // [RULE3]
        end
    end

    frpc_cmd_seq u_seq (
        .i_clock  (i_clock),
        .i_rstn   (i_rstn),
        .i_wr     (seq_wr),
        .i_byte   (i_wdata[7:0]),
        .i_enable (st_ff.op_en),
        .o_fire   (seq_fire)
    );

    frpc_array #(
        .DEPTH (frpc_pkg::FLASH_BYTES)                                     // [RULE1]
    ) u_array (
        .i_clock (i_clock),
        .i_we    (st_ff.arr_we),
        .i_addr  (st_ff.addr),
        .i_wdata (st_ff.data),
        .o_rdata (arr_rdata)
    );

    // -----------------------------------------------------------------
    // Register read mux
    // -----------------------------------------------------------------
    function automatic logic [32:0] read_mux(input frpc_pkg::frpc_state_s s,
                                             input logic [7:0] a);
        logic [31:0] v;
        logic        hit;
        v   = 32'h0000_0000;
        hit = 1'b1;
        unique case (a)
            frpc_pkg::OFS_CTRL: begin
                v[frpc_pkg::CTRL_EN_BIT]   = s.op_en;
                v[frpc_pkg::CTRL_FAIL_BIT] = s.fail;
                v[frpc_pkg::CTRL_LOCK_BIT] = s.lock;
            end
            frpc_pkg::OFS_MODE:  v[2:0]  = s.mode;
            frpc_pkg::OFS_ADDR:  v[11:0] = s.addr;
            frpc_pkg::OFS_DATA:  v[7:0]  = s.data;
            frpc_pkg::OFS_CMD:   v       = 32'h0000_0000;
            frpc_pkg::OFS_BOUND: v[7:0]  = s.bound;
            frpc_pkg::OFS_STAT:  v[0]    = s.halt;
            frpc_pkg::OFS_ISTS:  v[1:0]  = s.irq_sts;
            frpc_pkg::OFS_IMSK:  v[1:0]  = s.irq_msk;
            default:             hit     = 1'b0;
        endcase
        read_mux = {hit, v};
    endfunction : read_mux

    // -----------------------------------------------------------------
    // Next-state logic
    // -----------------------------------------------------------------
    always_comb begin
        logic [32:0] rd;
        logic        wr_hit;
        rd            = read_mux(st_ff, i_araddr);
        wr_hit        = 1'b1;
        nxt_st        = st_ff;
        nxt_st.arr_we = 1'b0;

        // Write channel: take address and data together
        if (wr_go) begin
            nxt_st.awready = 1'b0;
            nxt_st.wready  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            unique case (i_awaddr)
                frpc_pkg::OFS_CTRL: begin
                    if (i_wstrb[0]) begin
                        nxt_st.op_en = i_wdata[frpc_pkg::CTRL_EN_BIT];
                    end
                end
                frpc_pkg::OFS_MODE: begin
                    if (i_wstrb[0]) begin
                        nxt_st.mode = i_wdata[2:0];
                    end
                end
                frpc_pkg::OFS_ADDR: begin
                    if (i_wstrb[0]) begin
                        nxt_st.addr[7:0] = i_wdata[7:0];
                    end
                    if (i_wstrb[1]) begin
                        nxt_st.addr[11:8] = i_wdata[11:8];
                    end
                end
                frpc_pkg::OFS_DATA: begin
                    if (i_wstrb[0]) begin
                        nxt_st.data = i_wdata[7:0];
                    end
                end
                frpc_pkg::OFS_ISTS: begin
                    if (i_wstrb[0]) begin
                        nxt_st.irq_sts = st_ff.irq_sts & ~i_wdata[1:0];
                    end
                end
                frpc_pkg::OFS_IMSK: begin
                    if (i_wstrb[0]) begin
                        nxt_st.irq_msk = i_wdata[1:0];
                    end
                end
                frpc_pkg::OFS_CMD, frpc_pkg::OFS_BOUND, frpc_pkg::OFS_STAT: begin
                    wr_hit = 1'b1;
                end
                default: wr_hit = 1'b0;
            endcase
            nxt_st.bresp = wr_hit ? frpc_pkg::RESP_OKAY : frpc_pkg::RESP_SLVERR;
        end else if (!st_ff.awready && !st_ff.bvalid && i_awvalid && i_wvalid) begin
            nxt_st.awready = 1'b1;
            nxt_st.wready  = 1'b1;
        end
        if (st_ff.bvalid && i_bready) begin
            nxt_st.bvalid = 1'b0;
        end

        // Read channel
        if (rd_go) begin
            nxt_st.arready = 1'b0;
            nxt_st.rvalid  = 1'b1;
            nxt_st.rdata   = rd[31:0];
            nxt_st.rresp   = rd[32] ? frpc_pkg::RESP_OKAY : frpc_pkg::RESP_SLVERR;
        end else if (!st_ff.rvalid && i_arvalid) begin
            nxt_st.arready = 1'b1;
        end
        if (st_ff.rvalid && i_rready) begin
            nxt_st.rvalid = 1'b0;
        end

        // Flash operation sequencer
        unique case (st_ff.fsm)
            frpc_pkg::ST_IDLE: begin
                if (seq_fire) begin                                        // [RULE8]
                    nxt_st.fsm = frpc_pkg::ST_CHECK;
                end
            end
            frpc_pkg::ST_CHECK: begin
                nxt_st.fsm = frpc_pkg::ST_RUN;
                nxt_st.cnt = frpc_pkg::OP_CYCLES;
                unique case (st_ff.mode)                                   // [RULE9]
                    frpc_pkg::OP_STANDBY: begin
                        nxt_st.fsm  = frpc_pkg::ST_DONE;
                        nxt_st.fail = 1'b0;                                // [RULE10]
                    end
                    frpc_pkg::OP_READ: begin
                        nxt_st.cnt = frpc_pkg::OP_CYCLES;
                    end
                    frpc_pkg::OP_PROG: begin
                        if (permit) begin                                  // [RULE12]
                            nxt_st.arr_we = 1'b1;
                        end else begin
                            nxt_st.fail = 1'b1;                            // [RULE10]
                            nxt_st.fsm  = frpc_pkg::ST_DONE;
                        end
                    end
                    frpc_pkg::OP_PAGEP: begin
                        nxt_st.bound = {st_ff.data[7:1], 1'b0};            // [RULE11]
                    end
                    default: begin
                        nxt_st.fail = 1'b1;                                // [RULE9]
                        nxt_st.fsm  = frpc_pkg::ST_DONE;
                    end
                endcase
                if (nxt_st.fsm == frpc_pkg::ST_RUN) begin
                    nxt_st.fail = 1'b0;                                    // [RULE10]
                end
            end
            frpc_pkg::ST_RUN: begin
                nxt_st.cnt = st_ff.cnt - 3'h1;
                if (st_ff.cnt == 3'h1) begin
                    nxt_st.fsm = frpc_pkg::ST_DONE;
                end
            end
            frpc_pkg::ST_DONE: begin
                if (st_ff.mode == frpc_pkg::OP_READ && !st_ff.fail) begin
                    nxt_st.data = arr_rdata;
                end
                nxt_st.irq_sts[frpc_pkg::IRQ_DONE_BIT] = 1'b1;
                if (st_ff.fail) begin
                    nxt_st.irq_sts[frpc_pkg::IRQ_FAIL_BIT] = 1'b1;
                end
                nxt_st.fsm = frpc_pkg::ST_IDLE;                            // [RULE5]
            end
        endcase

        nxt_st.halt = nxt_st.fsm != frpc_pkg::ST_IDLE;                     // [RULE4] [RULE6]
        nxt_st.irq  = |(nxt_st.irq_sts & nxt_st.irq_msk);
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff       <= '0;
            st_ff.fsm   <= frpc_pkg::ST_IDLE;
            st_ff.bound <= frpc_pkg::LOW_BOUND_RST;                        // [RULE7]
            st_ff.lock  <= frpc_pkg::LOCK_RST;                             // [RULE7]
        end else begin
            st_ff <= nxt_st;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign o_awready   = st_ff.awready;
    assign o_wready    = st_ff.wready;
    assign o_bvalid    = st_ff.bvalid;
    assign o_bresp     = st_ff.bresp;
    assign o_arready   = st_ff.arready;
    assign o_rvalid    = st_ff.rvalid;
    assign o_rdata     = st_ff.rdata;
    assign o_rresp     = st_ff.rresp;
    assign o_core_halt = st_ff.halt;
    assign o_irq_defer = st_ff.halt;
    assign o_irq       = st_ff.irq;

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    localparam int HALT_MAX = 8;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);

    sequence s_check_prog;
        st_ff.fsm == frpc_pkg::ST_CHECK && st_ff.mode == frpc_pkg::OP_PROG;
    endsequence

    property p_fire_halts;
        seq_fire && st_ff.fsm == frpc_pkg::ST_IDLE |=> ##1 o_core_halt;
    endproperty
    a_fire_halts: assert property (p_fire_halts) else $error("core not halted"); // [RULE4]

    property p_release;
        $rose(o_core_halt) |-> ##[1:HALT_MAX] !o_core_halt;
    endproperty
    a_release: assert property (p_release) else $error("core not released"); // [RULE5]

    property p_defer;
        o_irq_defer == o_core_halt && (st_ff.fsm != frpc_pkg::ST_IDLE) == o_core_halt;
    endproperty
    a_defer: assert property (p_defer) else $error("interrupts not deferred"); // [RULE6]

    property p_fire_needs_en;
        seq_fire |-> $past(st_ff.op_en) && $past(i_wdata[7:0]) == frpc_pkg::CMD_KEY_SECOND;
    endproperty
    a_fire_needs_en: assert property (p_fire_needs_en) else $error("bad launch"); // [RULE8]

    property p_app_reject;
        s_check_prog ##0 (fetch_reg != frpc_pkg::REG_BOOT
                          && target_reg != frpc_pkg::REG_DATA)
        |=> st_ff.fail && !st_ff.arr_we ##1 st_ff.irq_sts[frpc_pkg::IRQ_FAIL_BIT];
    endproperty
    a_app_reject: assert property (p_app_reject) else $error("illegal program"); // [RULE3]

    property p_boot_permit;
        s_check_prog ##0 (fetch_reg == frpc_pkg::REG_BOOT
                          && target_reg != frpc_pkg::REG_BOOT)
        |=> st_ff.arr_we && !st_ff.fail;
    endproperty
    a_boot_permit: assert property (p_boot_permit) else $error("boot program lost"); // [RULE2]

    property p_reserved_fail;
        st_ff.fsm == frpc_pkg::ST_CHECK && st_ff.mode[2] && st_ff.mode[1:0] != 2'h0
        |=> st_ff.fail && st_ff.fsm == frpc_pkg::ST_DONE;
    endproperty
    a_reserved_fail: assert property (p_reserved_fail) else $error("reserved code ran"); // [RULE9]

    property p_bound_write;
        st_ff.fsm == frpc_pkg::ST_CHECK && st_ff.mode == frpc_pkg::OP_PAGEP
        |=> st_ff.bound == {$past(st_ff.data[7:1]), 1'b0} && !st_ff.fail;
    endproperty
    a_bound_write: assert property (p_bound_write) else $error("bound not written"); // [RULE11]

    property p_run_clears_fail;
        st_ff.fsm == frpc_pkg::ST_RUN |-> !st_ff.fail;
    endproperty
    a_run_clears_fail: assert property (p_run_clears_fail) else $error("fail stuck"); // [RULE10]

    property p_standby_clears;
        st_ff.fsm == frpc_pkg::ST_CHECK && st_ff.mode == frpc_pkg::OP_STANDBY
        |=> !st_ff.fail && st_ff.fsm == frpc_pkg::ST_DONE;
    endproperty
    a_standby_clears: assert property (p_standby_clears) else $error("standby fail"); // [RULE10]
endmodule : frpc_top

// *** testbench/frpc_core_model.sv ***
// Behavioural processor core that fetches and freezes on halt
module frpc_core_model (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    // Control
    input  wire logic        i_halt,
    input  wire logic [11:0] i_base,
    // Fetch
    output logic [11:0]      o_fetch_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] pc_ff;
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            pc_ff <= 4'h0;
        end else if (!i_halt) begin
            pc_ff <= pc_ff + 4'h1;
        end
    end
    assign o_fetch_addr = i_base | {8'h00, pc_ff};
endmodule : frpc_core_model

// *** testbench/frpc_top_tb.sv ***
// Self-checking bench for the flash region program control block
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (e)); end end
module frpc_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clock, i_rstn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, halt, defer, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0]  bresp, rresp, rs, bs;
    logic [11:0] base, fetch;
    logic [3:0]  wstrb;
    int          bad_count, n_tests, cycles, halt_seen;

    frpc_top uut (.i_clock(i_clock), .i_rstn(i_rstn), .i_awvalid(awvalid),
        .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
        .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
        .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
        .i_fetch_addr(fetch), .o_core_halt(halt), .o_irq_defer(defer), .o_irq(irq));
    frpc_core_model core (.i_clock(i_clock), .i_rstn(i_rstn), .i_halt(halt),
        .i_base(base), .o_fetch_addr(fetch));

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge i_clock);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            n++;
        end while (bvalid !== 1'b1 && n < 50);
        bs = bresp;
        bready <= 1'b0;
        if (n >= 50) bad_count++;
        @(posedge i_clock);
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge i_clock);
            if (arready === 1'b1) arvalid <= 1'b0;
            n++;
        end while (rvalid !== 1'b1 && n < 50);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (n >= 50) bad_count++;
        @(posedge i_clock);
    endtask : rdr

    task automatic launch(input logic [2:0] op, input logic [11:0] ta, input logic [7:0] d);
        logic [11:0] held;
        held = 12'h000;
        wr(frpc_pkg::OFS_MODE, {29'h0, op});
        wr(frpc_pkg::OFS_ADDR, {20'h0, ta});
        wr(frpc_pkg::OFS_DATA, {24'h0, d});
        wr(frpc_pkg::OFS_CTRL, 32'h80);
        wr(frpc_pkg::OFS_CMD, {24'h0, frpc_pkg::CMD_KEY_FIRST});
        wr(frpc_pkg::OFS_CMD, {24'h0, frpc_pkg::CMD_KEY_SECOND});
        halt_seen = 0;
        repeat (20) begin
            @(posedge i_clock);
            `CHK(defer, halt)
            if (halt === 1'b1) begin
                if (halt_seen == 0) held = fetch;
                `CHK(fetch, held)
                halt_seen++;
            end
        end
        if (halt_seen > 0) `CHK(fetch !== held, 1'b1)
        rdr(frpc_pkg::OFS_CTRL);
    endtask : launch

    task automatic t_reset;
        rdr(frpc_pkg::OFS_CTRL);
        `CHK(rd & 32'h11, 32'h01)
        rdr(frpc_pkg::OFS_BOUND);
        `CHK(rd, 32'h08)
        rdr(8'h40);
        `CHK(rs, frpc_pkg::RESP_SLVERR)
        wr(8'h40, 32'h0);
        `CHK(bs, frpc_pkg::RESP_SLVERR)
        $display("test reset done");
    endtask : t_reset

    task automatic t_perm;
        logic [11:0] fb[6] = '{12'hC00, 12'hC00, 12'hC00, 12'h000, 12'h000, 12'h000};
        logic [11:0] ta[6] = '{12'h100, 12'h900, 12'hC10, 12'h100, 12'h800, 12'h7FF};
        logic [7:0]  dv[6] = '{8'h5A, 8'h33, 8'h11, 8'hA5, 8'h44, 8'h66};
        logic        fl[6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 6; i++) begin
            base <= fb[i];
            launch(frpc_pkg::OP_PROG, ta[i], dv[i]);
            `CHK(rd[4], fl[i])
            if (!fl[i]) `CHK(halt_seen > 0, 1'b1)
        end
        launch(frpc_pkg::OP_READ, 12'h100, 8'h00);
        rdr(frpc_pkg::OFS_DATA);
        `CHK(rd, 32'h5A)
        launch(frpc_pkg::OP_READ, 12'h800, 8'h00);
        rdr(frpc_pkg::OFS_DATA);
        `CHK(rd, 32'h44)
        $display("test permission done");
    endtask : t_perm

    task automatic t_ops;
        for (int c = 0; c < 8; c++) begin
            if (c != 1 && c != 2) begin
                launch(3'(c), 12'h800, 8'h0A);
                `CHK(rd[4], logic'(c != 0 && c != 4))
            end
        end
        rdr(frpc_pkg::OFS_BOUND);
        `CHK(rd, 32'h0A)
        $display("test select codes done");
    endtask : t_ops

    task automatic t_irq;
        wr(frpc_pkg::OFS_ISTS, 32'h3);
        wr(frpc_pkg::OFS_IMSK, 32'h0);
        `CHK(bs, frpc_pkg::RESP_OKAY)
        launch(frpc_pkg::OP_STANDBY, 12'h800, 8'h00);
        @(posedge i_clock);
        `CHK(irq, 1'b0)
        rdr(frpc_pkg::OFS_ISTS);
        `CHK(rd[1:0], 2'h1)
        wr(frpc_pkg::OFS_IMSK, 32'h1);
        @(posedge i_clock);
        `CHK(irq, 1'b1)
        wr(frpc_pkg::OFS_ISTS, 32'h3);
        @(posedge i_clock);
        `CHK(irq, 1'b0)
        rdr(frpc_pkg::OFS_ISTS);
        `CHK(rd[1:0], 2'h0)
        $display("test interrupt done");
    endtask : t_irq

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    initial begin
        {i_rstn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, base} = 60'h0;
        wstrb = 4'hF;
        repeat (5) @(posedge i_clock);
        i_rstn <= 1'b1;
        @(posedge i_clock);
        t_reset();
        t_perm();
        t_ops();
        t_irq();
        stop_test();
    end
endmodule : frpc_top_tb
